// [core/ait_pkg.sv]
package ait_pkg;

   // -----------------------------------------------------------------
   // Clock and serial link timing
   // -----------------------------------------------------------------
   localparam int unsigned MCLK_HZ      = 25_000_000;
   localparam int unsigned SCLK_MAX_HZ  = 20_000_000;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [6:0] ADDR_COARSE_UP  = 7'h30;
   localparam logic [6:0] ADDR_COARSE_MID = 7'h31;
   localparam logic [6:0] ADDR_COARSE_LOW = 7'h32;
   localparam logic [6:0] ADDR_FINE_UP    = 7'h33;
   localparam logic [6:0] ADDR_FINE_MID   = 7'h34;
   localparam logic [6:0] ADDR_FINE_LOW   = 7'h35;
   localparam logic [6:0] ADDR_LANE_PICK  = 7'h0f;
   localparam logic [6:0] ADDR_CAL_CTRL   = 7'h10;

   // -----------------------------------------------------------------
   // Field layout, reset values and frame counts
   // -----------------------------------------------------------------
   localparam int          NUM_LANES     = 4;
   localparam int          NUM_TRIM_REGS = 6;
   localparam int          NUM_CODES     = 17;
   localparam int          CAL_GO_BIT    = 0;
   localparam logic [4:0]  HDR_BITS      = 5'h08;
   localparam logic [4:0]  FRAME_BITS    = 5'h18;
   localparam logic [4:0]  CNT_OVER      = 5'h19;
   localparam logic [15:0] TRIM_RESET    = 16'h0000;
   localparam logic [15:0] LOW_REG_MASK  = 16'hff00;
   localparam logic [1:0]  LANE_RESET    = 2'h0;
   localparam logic [2:0]  PIN_IDLE      = 3'h2;
   localparam logic signed [3:0] FINE_STEP   = 4'sh1;
   localparam logic signed [3:0] COARSE_STEP = 4'sh3;

   // -----------------------------------------------------------------
   // Types and helpers
   // -----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_ARMED = 2'b11
   } ait_state_t;

   function automatic logic is_trim_addr(input logic [6:0] addr);
      return (addr >= ADDR_COARSE_UP) && (addr <= ADDR_FINE_LOW);
   endfunction

   function automatic logic [2:0] trim_index(input logic [6:0] addr);
      logic [6:0] diff;
      diff = addr - ADDR_COARSE_UP;
      return diff[2:0];
   endfunction

   function automatic logic is_low_reg(input logic [2:0] idx);
      return (idx == 3'h2) || (idx == 3'h5);
   endfunction

endpackage

// [core/ait_trim_decode.sv]
module ait_trim_decode
   import ait_pkg::*;
(
   input  wire logic                    i_mclk,
   input  wire logic                    i_reset_n,
   input  wire logic [6*16-1:0]         i_trim,
   output logic      [NUM_CODES*4-1:0]  o_shift
);

   // -----------------------------------------------------------------
   // Code to register and bit position
   // -----------------------------------------------------------------
   function automatic logic [5:0] code_pos(input int code);
      logic [1:0] reg_sel;
      logic [3:0] bit_sel;
      reg_sel = 2'h0;
      bit_sel = 4'h0;
      if (code < 4)
      begin
         reg_sel = 2'h2;
         bit_sel = 4'(8 + 2 * code);
      end
      else if (code < 12)
      begin
         reg_sel = 2'h1;
         bit_sel = 4'(2 * (code - 4));
      end
      else
      begin
         reg_sel = 2'h0;
         bit_sel = 4'(2 * (code - 12));
      end
      return {reg_sel, bit_sel};
   endfunction

   logic [NUM_CODES*4-1:0] shift_d;
   logic [NUM_CODES*4-1:0] shift_q;

   // -----------------------------------------------------------------
   // Net nonlinearity shift per code in steps of 0.15 LSB
   // -----------------------------------------------------------------
   always_comb
   begin
      logic [5:0]        pos;
      logic [15:0]       coarse;
      logic [15:0]       fine;
      logic signed [3:0] sum;
      pos    = 6'h00;
      coarse = 16'h0000;
      fine   = 16'h0000;
      sum    = 4'sh0;
      shift_d = '0;
      for (int c = 0; c < NUM_CODES; c++)
      begin
         pos    = code_pos(c);
         coarse = i_trim[int'(pos[5:4])*16 +: 16];
         fine   = i_trim[(int'(pos[5:4]) + 3)*16 +: 16];
         sum    = 4'sh0;
         if (fine[pos[3:0]])
            sum = sum + FINE_STEP;
         if (fine[pos[3:0] + 4'h1])
            sum = sum - FINE_STEP;
         if (coarse[pos[3:0]])
            sum = sum + COARSE_STEP;
         if (coarse[pos[3:0] + 4'h1])
            sum = sum - COARSE_STEP;
         shift_d[c*4 +: 4] = sum;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         shift_q <= '0;
      else
         shift_q <= shift_d;
   end

   assign o_shift = shift_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_fine_raise_128: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (i_trim[4*16+8] && !i_trim[4*16+9] && !i_trim[1*16+8] && !i_trim[1*16+9])
      |=> (o_shift[8*4 +: 4] == 4'h1))
      else $error("fine raise at code 128 is not one step");
   a_coarse_raise_0: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (i_trim[2*16+8] && !i_trim[2*16+9] && !i_trim[5*16+8] && !i_trim[5*16+9])
      |=> (o_shift[3:0] == 4'h3))
      else $error("coarse raise at code 0 is not three steps");
   a_sum_raise_255: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (i_trim[0*16+8] && i_trim[3*16+8] && !i_trim[0*16+9] && !i_trim[3*16+9])
      |=> (o_shift[16*4 +: 4] == 4'h4))
      else $error("combined raise at code 255 is not four steps");
   a_lower_pair_192: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (i_trim[0*16+1] && i_trim[3*16+1] && !i_trim[0*16+0] && !i_trim[3*16+0])
      |=> (o_shift[12*4 +: 4] == 4'hc))
      else $error("combined lower at code 192 is not minus four steps");

endmodule

// [core/ait_trim_regs.sv]
// Function
// - Fine bit shifts its code 0.15 LSB.
// - Coarse bit shifts its code 0.45 LSB.
// - Coarse and fine together add to 0.6.
// - Even bit raises, next odd bit lowers.
// - Codes 0-48 in bits 8-15 of 0x32/0x35.
// - Codes 64-176 in bits 0-15 of 0x31/0x34.
// - Codes 192-240 low byte, 255 bits 8-9.
// - Trim accesses reach the selected lane copy.
// - Trim applies after calibration transfer request.
module ait_trim_regs
   import ait_pkg::*;
(
   input  wire logic                              i_mclk,
   input  wire logic                              i_reset_n,
   input  wire logic                              i_sclk,
   input  wire logic                              i_csn,
   input  wire logic                              i_mosi,
   output logic                                   o_miso,
   output logic                                   o_miso_oe,
   output logic [1:0]                             o_lane_pick,
   output logic [NUM_LANES*NUM_CODES*4-1:0]       o_trim_shift
);

   // -----------------------------------------------------------------
   // Pin synchronisers: change accepted when stages two and three agree
   // -----------------------------------------------------------------
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] filt_q;
   logic [2:0] filt_d;

   always_comb
   begin
      filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         s1_q   <= PIN_IDLE;
         s2_q   <= PIN_IDLE;
         s3_q   <= PIN_IDLE;
         filt_q <= PIN_IDLE;
      end
      else
      begin
         s1_q   <= {i_sclk, i_csn, i_mosi};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic csn_rise;
   logic csn_fall;
   logic csn_hi;
   logic mosi_bit;

   assign sclk_rise = filt_d[2] & ~filt_q[2];
   assign sclk_fall = ~filt_d[2] & filt_q[2];
   assign csn_rise  = filt_d[1] & ~filt_q[1];
   assign csn_fall  = ~filt_d[1] & filt_q[1];
   assign csn_hi    = filt_d[1];
   assign mosi_bit  = filt_d[0];

   // -----------------------------------------------------------------
   // Register storage
   // -----------------------------------------------------------------
   logic [15:0] trim_q   [NUM_LANES][NUM_TRIM_REGS];
   logic [15:0] trim_d   [NUM_LANES][NUM_TRIM_REGS];
   logic [15:0] active_q [NUM_LANES][NUM_TRIM_REGS];
   logic [15:0] active_d [NUM_LANES][NUM_TRIM_REGS];
   logic [1:0]  lane_q;
   logic [1:0]  lane_d;

   function automatic logic [15:0] reg_read(input logic [6:0] addr, input logic [1:0] lane,
                                            input logic [15:0] regs [NUM_LANES][NUM_TRIM_REGS]);
      logic [15:0] val;
      val = 16'h0000;
      if (is_trim_addr(addr))
         val = regs[lane][trim_index(addr)];
      else if (addr == ADDR_LANE_PICK)
         val = {14'h0000, lane};
      return val;
   endfunction

   // -----------------------------------------------------------------
   // Frame engine
   // -----------------------------------------------------------------
   ait_state_t  state_q;
   ait_state_t  state_d;
   logic [4:0]  cnt_q;
   logic [4:0]  cnt_d;
   logic [23:0] in_q;
   logic [23:0] in_d;
   logic [6:0]  wr_addr_q;
   logic [6:0]  wr_addr_d;
   logic [15:0] wr_data_q;
   logic [15:0] wr_data_d;
   logic [15:0] out_q;
   logic [15:0] out_d;
   logic        miso_q;
   logic        miso_d;
   logic        oe_q;
   logic        oe_d;
   logic        wr_en;
   logic [15:0] rd_val;

   assign rd_val = reg_read(in_q[6:0], lane_q, trim_q);

   always_comb
   begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      in_d      = in_q;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      out_d     = out_q;
      miso_d    = miso_q;
      oe_d      = ~csn_hi;
      wr_en     = 1'b0;
      case (state_q)
         ST_IDLE, ST_ARMED:
         begin
            if (state_q == ST_ARMED && csn_hi && sclk_fall)
            begin
               wr_en   = 1'b1;
               state_d = ST_IDLE;
            end
            if (csn_fall)
            begin
               state_d = ST_SHIFT;
               cnt_d   = 5'h00;
               miso_d  = 1'b0;
            end
         end
         ST_SHIFT:
         begin
            if (sclk_rise && cnt_q != CNT_OVER)
            begin
               in_d  = {in_q[22:0], mosi_bit};
               cnt_d = cnt_q + 5'h01;
            end
            if (sclk_fall && !in_q[cnt_q - 5'h01] && cnt_q >= HDR_BITS && cnt_q < FRAME_BITS)
            begin
               if (cnt_q == HDR_BITS)
               begin
                  miso_d = rd_val[15];
                  out_d  = {rd_val[14:0], 1'b0};
               end
               else
               begin
                  miso_d = out_q[15];
                  out_d  = {out_q[14:0], 1'b0};
               end
            end
            if (csn_rise)
            begin
               state_d = ST_IDLE;
               if (cnt_q == FRAME_BITS && in_q[23])
               begin
                  state_d   = ST_ARMED;
                  wr_addr_d = in_q[22:16];
                  wr_data_d = in_q[15:0];
               end
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Register update
   // -----------------------------------------------------------------
   always_comb
   begin
      logic [2:0] idx;
      idx      = trim_index(wr_addr_q);
      trim_d   = trim_q;
      active_d = active_q;
      lane_d   = lane_q;
      if (wr_en)
      begin
         if (is_trim_addr(wr_addr_q))
            trim_d[lane_q][idx] = is_low_reg(idx) ? (wr_data_q & LOW_REG_MASK)
                                                  : wr_data_q;
         else if (wr_addr_q == ADDR_LANE_PICK)
            lane_d = wr_data_q[1:0];
         else if (wr_addr_q == ADDR_CAL_CTRL && wr_data_q[CAL_GO_BIT])
            active_d[lane_q] = trim_q[lane_q];
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_q   <= ST_IDLE;
         cnt_q     <= 5'h00;
         in_q      <= 24'h000000;
         wr_addr_q <= 7'h00;
         wr_data_q <= 16'h0000;
         out_q     <= 16'h0000;
         miso_q    <= 1'b0;
         oe_q      <= 1'b0;
         lane_q    <= LANE_RESET;
         for (int l = 0; l < NUM_LANES; l++)
         begin
            for (int r = 0; r < NUM_TRIM_REGS; r++)
            begin
               trim_q[l][r]   <= TRIM_RESET;
               active_q[l][r] <= TRIM_RESET;
            end
         end
      end
      else
      begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         in_q      <= in_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         out_q     <= out_d;
         miso_q    <= miso_d;
         oe_q      <= oe_d;
         lane_q    <= lane_d;
         trim_q    <= trim_d;
         active_q  <= active_d;
      end
   end

   assign o_miso      = miso_q;
   assign o_miso_oe   = oe_q;
   assign o_lane_pick = lane_q;

   // -----------------------------------------------------------------
   // Applied trim per lane
   // -----------------------------------------------------------------
   logic [NUM_LANES*96-1:0] trim_flat;
   logic [NUM_LANES*96-1:0] active_flat;

   for (genvar l = 0; l < NUM_LANES; l++)
   begin : g_lane
      for (genvar r = 0; r < NUM_TRIM_REGS; r++)
      begin : g_reg
         assign trim_flat[l*96 + r*16 +: 16]   = trim_q[l][r];
         assign active_flat[l*96 + r*16 +: 16] = active_q[l][r];
      end
      ait_trim_decode u_decode
      (
         .i_mclk    (i_mclk),
         .i_reset_n (i_reset_n),
         .i_trim    (active_flat[l*96 +: 96]),
         .o_shift   (o_trim_shift[l*NUM_CODES*4 +: NUM_CODES*4])
      );
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   logic [95:0] sel_trim;
   logic [95:0] sel_active;
   assign sel_trim   = trim_flat[int'(lane_q)*96 +: 96];
   assign sel_active = active_flat[int'(lane_q)*96 +: 96];

   a_write_on_fall: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      wr_en |-> (sclk_fall && csn_hi && $past(state_q) == ST_ARMED))
      else $error("write committed without closing clock fall");
   a_trim_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      !(wr_en && is_trim_addr(wr_addr_q)) |=> $stable(trim_flat))
      else $error("trim storage changed without a write");
   a_trim_store: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (wr_en && wr_addr_q == ADDR_FINE_MID)
      |=> (sel_trim[4*16 +: 16] == $past(wr_data_q)))
      else $error("trim write missed the selected lane copy");
   a_lane_store: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (wr_en && wr_addr_q == ADDR_LANE_PICK) |=> (o_lane_pick == $past(wr_data_q[1:0])))
      else $error("lane pick not stored");
   a_cal_only: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      !(wr_en && wr_addr_q == ADDR_CAL_CTRL && wr_data_q[CAL_GO_BIT]) |=> $stable(active_flat))
      else $error("applied trim changed without a transfer");
   a_cal_copy: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (wr_en && wr_addr_q == ADDR_CAL_CTRL && wr_data_q[CAL_GO_BIT])
      |=> (sel_active == $past(sel_trim)) ##1 $stable(sel_active))
      else $error("transfer did not copy the selected lane");
   a_low_reserved: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (sel_trim[2*16 +: 8] == 8'h00) && (sel_trim[5*16 +: 8] == 8'h00))
      else $error("reserved low byte of lower-code register is not zero");
   a_oe_follows: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      $fell(filt_q[1]) |-> ##[1:2] o_miso_oe)
      else $error("read data driver not enabled in frame");

   c_write_done: cover property (@(posedge i_mclk) disable iff (!i_reset_n) wr_en);
   c_cal_xfer: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
      wr_en && wr_addr_q == ADDR_CAL_CTRL && wr_data_q[CAL_GO_BIT]);
   c_read_frame: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_q == ST_SHIFT && csn_rise && cnt_q == FRAME_BITS && !in_q[23]);

endmodule

// [bench/ait_spi_host.sv]
module ait_spi_host
(
   input  wire logic        i_mclk,
   input  wire logic        i_miso,
   output logic             o_sclk,
   output logic             o_csn,
   output logic             o_mosi,
   output logic             o_rd_strobe,
   output logic [15:0]      o_rd_word
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Idle pin levels
   // ---------------------------------------------------------------
   initial
   begin
      o_sclk      = 1'b0;
      o_csn       = 1'b1;
      o_mosi      = 1'b0;
      o_rd_strobe = 1'b0;
      o_rd_word   = 16'h0000;
   end

   // ---------------------------------------------------------------
   // Frame driver
   // ---------------------------------------------------------------
   task automatic half();
      repeat (6) @(posedge i_mclk);
      #1;
   endtask

   task automatic frame(input logic wr, input logic [6:0] addr,
                        input logic [15:0] data, input logic close);
      logic [23:0] bits;
      logic [15:0] rd;
      bits = {wr, addr, data};
      rd = 16'h0000;
      o_csn = 1'b0;
      half();
      for (int i = 23; i >= 0; i--)
      begin
         o_mosi = bits[i];
         half();
         if (i < 16)
            rd[i] = i_miso;
         o_sclk = 1'b1;
         half();
         o_sclk = 1'b0;
      end
      half();
      o_csn = 1'b1;
      o_mosi = ~o_mosi;
      half();
      if (close)
      begin
         o_sclk = 1'b1;
         half();
         o_sclk = 1'b0;
         half();
      end
      if (!wr)
      begin
         o_rd_word = rd;
         o_rd_strobe = 1'b1;
         @(posedge i_mclk);
         #1;
         o_rd_strobe = 1'b0;
      end
   endtask
endmodule

// [bench/ait_trim_regs_tb.sv]
module ait_trim_regs_tb
   import ait_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic         mclk;
   logic         reset_n;
   logic         sclk;
   logic         csn;
   logic         mosi;
   logic         miso;
   logic         miso_oe;
   logic [1:0]   lane_pick;
   logic [271:0] shift;
   logic         rd_stb;
   logic [15:0]  rd_word;
   logic [15:0]  mir [4][6];
   logic [15:0]  app [4][6];
   logic [1:0]   lane;
   logic [15:0]  expq [$];
   int           compares;
   int           miscompares;
   int           seed;

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   ait_trim_regs DUT
   (
      .i_mclk       (mclk),
      .i_reset_n    (reset_n),
      .i_sclk       (sclk),
      .i_csn        (csn),
      .i_mosi       (mosi),
      .o_miso       (miso),
      .o_miso_oe    (miso_oe),
      .o_lane_pick  (lane_pick),
      .o_trim_shift (shift)
   );

   ait_spi_host u_host
   (
      .i_mclk      (mclk),
      .i_miso      (miso),
      .o_sclk      (sclk),
      .o_csn       (csn),
      .o_mosi      (mosi),
      .o_rd_strobe (rd_stb),
      .o_rd_word   (rd_word)
   );

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic logic [3:0] exp_nib(input int l, input int c);
      int ci;
      int b;
      int v;
      ci = (c < 4) ? 2 : (c < 12) ? 1 : 0;
      b = (c < 4) ? 8 + 2 * c : (c < 12) ? 2 * (c - 4) : (c < 16) ? 2 * (c - 12) : 8;
      v = int'(app[l][ci + 3][b]) - int'(app[l][ci + 3][b + 1]);
      v = v + 3 * (int'(app[l][ci][b]) - int'(app[l][ci][b + 1]));
      return v[3:0];
   endfunction

   function automatic logic [271:0] exp_vec();
      logic [271:0] v;
      v = '0;
      for (int l = 0; l < 4; l++)
         for (int c = 0; c < 17; c++)
            v[(l * 17 + c) * 4 +: 4] = exp_nib(l, c);
      return v;
   endfunction

   task automatic clear_model();
      for (int l = 0; l < 4; l++)
         for (int i = 0; i < 6; i++)
         begin
            mir[l][i] = 16'h0000;
            app[l][i] = 16'h0000;
         end
      lane = 2'h0;
   endtask

   // ---------------------------------------------------------------
   // Stimulus and checking tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [271:0] seen, input logic [271:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      u_host.frame(1'b1, a, d, 1'b1);
      if (a >= ADDR_COARSE_UP && a <= ADDR_FINE_LOW)
         mir[lane][3'(a - ADDR_COARSE_UP)] =
            (a == ADDR_COARSE_LOW || a == ADDR_FINE_LOW) ? (d & 16'hff00) : d;
      if (a == ADDR_LANE_PICK)
         lane = d[1:0];
      if (a == ADDR_CAL_CTRL && d[0])
         app[lane] = mir[lane];
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      expq.push_back(e);
      u_host.frame(1'b0, a, 16'h0000, 1'b1);
   endtask

   task automatic settle();
      repeat (4) @(posedge mclk);
      #1;
   endtask

   task automatic summarize();
      $display("Compares %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Read monitor
   // ---------------------------------------------------------------
   always @(posedge rd_stb)
   begin
      if (expq.size() == 0)
         check(272'(rd_word), 272'h1_0000);
      else
         check(272'(rd_word), 272'(expq.pop_front()));
   end

   always @(posedge sclk)
   begin
      check(272'(miso_oe), 272'(!csn));
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      seed = 32'h15c7;
      compares = 0;
      miscompares = 0;
      reset_n = 1'b0;
      clear_model();
      repeat (5) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      settle();
      check(272'(lane_pick), 272'h0);
      check(shift, exp_vec());
      for (int i = 0; i < 6; i++)
         rd(ADDR_COARSE_UP + 7'(i), 16'h0000);
      wr(ADDR_FINE_MID, 16'h0200);
      check(shift, exp_vec());
      wr(ADDR_CAL_CTRL, 16'h0001);
      settle();
      check(shift, exp_vec());
      wr(ADDR_COARSE_MID, 16'h0200);
      wr(ADDR_CAL_CTRL, 16'h0001);
      settle();
      check(shift, exp_vec());
      u_host.frame(1'b1, ADDR_FINE_MID, 16'hffff, 1'b0);
      rd(ADDR_FINE_MID, 16'h0200);
      wr(7'h50, 16'hffff);
      rd(7'h50, 16'h0000);
      rd(ADDR_CAL_CTRL, 16'h0000);
      wr(ADDR_COARSE_MID, 16'h0000);
      wr(ADDR_FINE_MID, 16'h0100);
      wr(ADDR_COARSE_LOW, 16'h0100);
      wr(ADDR_COARSE_UP, 16'h0102);
      wr(ADDR_FINE_UP, 16'h0102);
      wr(ADDR_CAL_CTRL, 16'h0001);
      settle();
      check(shift, exp_vec());
      for (int l = 3; l >= 0; l--)
      begin
         wr(ADDR_LANE_PICK, 16'(l));
         check(272'(lane_pick), 272'(l));
         for (int i = 0; i < 6; i++)
            wr(ADDR_COARSE_UP + 7'(i), 16'($random(seed)));
         for (int i = 0; i < 6; i++)
            rd(ADDR_COARSE_UP + 7'(i), mir[l][i]);
         wr(ADDR_CAL_CTRL, 16'h0001);
         settle();
         check(shift, exp_vec());
      end
      rd(ADDR_LANE_PICK, 16'h0000);
      reset_n = 1'b0;
      clear_model();
      repeat (2) @(posedge mclk);
      #1;
      check(shift, 272'h0);
      check(272'(lane_pick), 272'h0);
      reset_n = 1'b1;
      settle();
      rd(ADDR_COARSE_MID, 16'h0000);
      repeat (20) @(posedge mclk);
      if (expq.size() != 0)
         miscompares++;
      summarize();
   end

   initial
   begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      summarize();
   end
endmodule
